//--- hw/adc_conv_core.sv
module adc_conv_core (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 start,
	input  wire logic                 hold,
	input  wire adc_pkg::conv_cfg_type cfg,
	input  wire logic [11:0]          analog_data,
	output logic                      done,
	output logic [11:0]               raw,
	output logic                      sampling,
	output logic                      draining
);
	import adc_pkg::*;

	typedef enum logic [1:0] {
		PH_IDLE    = 2'b00,
		PH_DRAIN   = 2'b01,
		PH_SAMPLE  = 2'b10,
		PH_CONVERT = 2'b11
	} phase_type;

	typedef struct packed {
		phase_type   phase;
		logic [5:0]  cnt;
		logic [3:0]  div;
		logic [11:0] raw;
		logic        done;
		logic        sampling;
		logic        draining;
	} core_state_type;

	core_state_type st_r;
	core_state_type st_nxt;
	logic           tick;

	function automatic logic [5:0] sample_ticks(input logic [2:0] code);
		unique case (code)
			3'd0: sample_ticks = 6'd4;
			3'd1: sample_ticks = 6'd6;
			3'd2: sample_ticks = 6'd8;
			3'd3: sample_ticks = 6'd10;
			3'd4: sample_ticks = 6'd12;
			3'd5: sample_ticks = 6'd16;
			3'd6: sample_ticks = 6'd20;
			3'd7: sample_ticks = 6'd24;
		endcase
	endfunction

	// converter tick from the system clock; no second clock domain
	assign tick = (st_r.div == 4'(CONV_CLK_DIV - 1));

	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (!hold) begin
			st_nxt.div = tick ? 4'h0 : 4'(st_r.div + 4'h1);
		end
		if (start) begin
			st_nxt.div = 4'h0;
			st_nxt.phase = cfg.drain ? PH_DRAIN : PH_SAMPLE; // see RL2
			st_nxt.cnt = cfg.drain ? 6'(DRAIN_TICKS) : sample_ticks(cfg.sample_code); // see RL11
		end else if (!hold && tick) begin
			unique case (st_r.phase)
				PH_IDLE: begin
					st_nxt.cnt = 6'h00;
				end
				PH_DRAIN: begin
					if (st_r.cnt == 6'h01) begin
						st_nxt.phase = PH_SAMPLE;
						st_nxt.cnt = sample_ticks(cfg.sample_code); // see RL11
					end else begin
						st_nxt.cnt = st_r.cnt - 6'h01;
					end
				end
				PH_SAMPLE: begin
					if (st_r.cnt == 6'h01) begin
						st_nxt.phase = PH_CONVERT;
						st_nxt.raw = analog_data;
						// one tick per result bit
						st_nxt.cnt = (cfg.resolution == RES_8) ? 6'd8 :
							(cfg.resolution == RES_10) ? 6'd10 : 6'd12; // see RL3
					end else begin
						st_nxt.cnt = st_r.cnt - 6'h01;
					end
				end
				PH_CONVERT: begin
					if (st_r.cnt == 6'h01) begin
						st_nxt.phase = PH_IDLE;
						st_nxt.done = 1'b1;
						st_nxt.cnt = 6'h00;
					end else begin
						st_nxt.cnt = st_r.cnt - 6'h01;
					end
				end
			endcase
		end
		st_nxt.sampling = (st_nxt.phase == PH_SAMPLE);
		st_nxt.draining = (st_nxt.phase == PH_DRAIN);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done     = st_r.done;
	assign raw      = st_r.raw;
	assign sampling = st_r.sampling;
	assign draining = st_r.draining;
endmodule

//--- hw/adc_pkg.sv
package adc_pkg;
	localparam int         NUM_CH        = 16;
	localparam int         ADDR_W        = 8;
	// register byte addresses
	localparam logic [7:0] OFS_CTL0      = 8'h00;
	localparam logic [7:0] OFS_CTL1      = 8'h04;
	localparam logic [7:0] OFS_CTL2      = 8'h08;
	localparam logic [7:0] OFS_CTL3      = 8'h0C;
	localparam logic [7:0] OFS_CTL4      = 8'h10;
	localparam logic [7:0] OFS_CTL5      = 8'h14;
	localparam logic [7:0] OFS_STAT0     = 8'h18;
	localparam logic [7:0] OFS_CCF       = 8'h1C;
	localparam logic [7:0] OFS_CMPE      = 8'h20;
	localparam logic [7:0] OFS_CMPHT     = 8'h24;
	localparam logic [7:0] OFS_CMPF      = 8'h28;
	localparam logic [7:0] OFS_RES_BASE  = 8'h40;
	// field positions
	localparam int         CTL0_WRAP_LO  = 0;
	localparam int         CTL1_DRAIN    = 4;
	localparam int         CTL1_RES_LO   = 5;
	localparam int         CTL2_CMPIE    = 0;
	localparam int         CTL2_STOPCLK  = 5;
	localparam int         CTL2_FFC      = 6;
	localparam int         CTL3_LEN_LO   = 3;
	localparam int         CTL3_JUSTIFY  = 7;
	localparam int         CTL4_SMP_LO   = 5;
	localparam int         CTL4_SAMPLE_TIME_BIT2     = 7;
	localparam int         CTL5_CH_LO    = 0;
	localparam int         CTL5_MULT     = 4;
	localparam int         CTL5_SPECIAL  = 6;
	localparam int         STAT0_BUSY    = 0;
	localparam int         STAT0_CMP     = 6;
	localparam int         STAT0_SCF     = 7;
	// reset values
	localparam logic [7:0]  CTL0_RST     = 8'h0F;
	localparam logic [7:0]  CTL1_RST     = 8'h00;
	localparam logic [7:0]  CTL2_RST     = 8'h00;
	localparam logic [7:0]  CTL3_RST     = 8'h20;
	localparam logic [7:0]  CTL4_RST     = 8'h00;
	localparam logic [7:0]  CTL5_RST     = 8'h00;
	localparam logic [15:0] CMPE_RST     = 16'h0000;
	localparam logic [15:0] CMPHT_RST    = 16'h0000;
	// timing, in system clocks and converter ticks
	localparam int         CONV_CLK_DIV  = 2;
	localparam int         DRAIN_TICKS   = 2;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;
	localparam logic [1:0] RES_8         = 2'h0;
	localparam logic [1:0] RES_10        = 2'h1;

	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_m_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [1:0]  bresp;
		logic        bvalid;
		logic        arready;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        rvalid;
	} axi_s_type;

	typedef struct packed {
		logic       drain;
		logic [2:0] sample_code;
		logic [1:0] resolution;
	} conv_cfg_type;
endpackage

//--- hw/adc_sequencer_compare_ctrl.sv
// Operation
// RL1: wrap limit all ones on three low bits wraps selector from 7 to 0.
// RL2: drain bit in control 1 discharges the sample capacitor before each sample.
// RL3: two-bit resolution field in control 1 selects 8, 10 or 12 bits.
// RL4: stop-clock enable in control 2 keeps conversions running in stop.
// RL5: compare interrupt enable in control 2 gates the compare interrupt.
// RL6: compare flags result less-or-equal or greater than threshold, in every mode.
// RL7: compare events are flagged apart from conversion-complete flags.
// RL8: threshold is the value software last wrote to the channel result register.
// RL9: 16-bit compare enable, one bit per channel, resets to disabled.
// RL10: 16-bit higher-than select picks greater-than, else less-or-equal.
// RL11: third sample-time bit in control 4 joins the other two.
// RL12: special select in control 5 converts internal references.
// RL13: every write to control 5 starts a new sequence.
// RL14: justify bit aligns stored results and written thresholds alike.
// RL15: result registers are writable; a write replaces the last result.
// RL16: without fast clear, complete flags clear only by writing one.
// RL17: ready from reset, idle when not converting, no power-up bit.
// RL18: software aborts sequences itself before entering wait.
// RL19: compare match while stopped raises a wakeup request.
// RL20: results are unsigned; software forms signed values.
// RL21: with fast clear, any result register access clears its complete flag.
// RL22: sequence complete flag sets at the last conversion, apart from compare.
module adc_sequencer_compare_ctrl (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire adc_pkg::axi_m_type axi_m,
	output adc_pkg::axi_s_type     axi_s,
	input  wire logic              stop_mode,
	input  wire logic [11:0]       analog_data,
	output logic [3:0]             channel_sel,
	output logic                   special_sel,
	output logic                   sample_active,
	output logic                   discharge_active,
	output logic                   compare_irq,
	output logic                   wakeup_req
);
	import adc_pkg::*;

	typedef struct packed {
		axi_s_type           s;
		logic [7:0]          aw_addr;
		logic                aw_have;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                w_have;
		logic [7:0]          ctl0;
		logic [7:0]          ctl1;
		logic [7:0]          ctl2;
		logic [7:0]          ctl3;
		logic [7:0]          ctl4;
		logic [7:0]          ctl5;
		logic [15:0]         cmp_en;
		logic [15:0]         cmp_ht;
		logic [15:0]         ccf;
		logic [15:0]         cmp_flag;
		logic                sequence_complete_flag;
		logic [15:0][15:0]   result;
		logic                busy;
		logic [3:0]          ch;
		logic [4:0]          left;
		logic                start;
		logic                irq;
		logic                wake;
	} state_type;

	state_type    st_r;
	state_type    st_nxt;
	conv_cfg_type cfg;
	logic         conv_done;
	logic [11:0]  conv_raw;
	logic         conv_sampling;
	logic         conv_draining;
	logic         conv_hold;

	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] strb, input int lane);
		merge8 = strb[lane] ? d[lane*8 +: 8] : old;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		merge16 = {merge8(old[15:8], d, strb, 1), merge8(old[7:0], d, strb, 0)};
	endfunction

	function automatic logic is_result(input logic [7:0] a);
		is_result = (a[7:6] == OFS_RES_BASE[7:6]) && (a[1:0] == 2'b00);
	endfunction

	// scale to the chosen width, then place right or left in the 16-bit word
	function automatic logic [15:0] justify(input logic [11:0] raw, input logic [1:0] res,
		input logic left);
		logic [15:0] v;
		v = 16'h0000;
		unique case (res)
			RES_8:   v = left ? {raw[11:4], 8'h00} : {8'h00, raw[11:4]}; // see RL3
			RES_10:  v = left ? {raw[11:2], 6'h00} : {6'h00, raw[11:2]}; // see RL3
			default: v = left ? {raw, 4'h0} : {4'h0, raw}; // see RL14
		endcase
		justify = v;
	endfunction

	always_comb begin
		logic [7:0]  waddr;
		logic [7:0]  raddr;
		logic [3:0]  rch;
		logic [3:0]  wch;
		logic [3:0]  nch;
		logic [15:0] val;
		logic [15:0] thr;
		logic        match;
		logic [15:0] clr_ccf;
		logic [15:0] clr_cmp;
		logic        clr_scf;
		logic [31:0] rd;
		logic        rd_ok;
		waddr = st_r.aw_addr;
		raddr = axi_m.araddr;
		rch = raddr[5:2];
		wch = waddr[5:2];
		nch = 4'h0;
		val = 16'h0000;
		thr = 16'h0000;
		match = 1'b0;
		clr_ccf = 16'h0000;
		clr_cmp = 16'h0000;
		clr_scf = 1'b0;
		rd = 32'h0000_0000;
		rd_ok = 1'b1;
		st_nxt = st_r;
		st_nxt.start = 1'b0;

		// bus handshakes: address and data may come in either order
		if (axi_m.awvalid && st_r.s.awready) begin
			st_nxt.aw_have = 1'b1;
			st_nxt.aw_addr = axi_m.awaddr;
		end
		if (axi_m.wvalid && st_r.s.wready) begin
			st_nxt.w_have = 1'b1;
			st_nxt.w_data = axi_m.wdata;
			st_nxt.w_strb = axi_m.wstrb;
		end
		if (st_r.s.bvalid && axi_m.bready) begin
			st_nxt.s.bvalid = 1'b0;
		end
		if (st_r.s.rvalid && axi_m.rready) begin
			st_nxt.s.rvalid = 1'b0;
		end

		// register write, once both halves are held
		if (st_r.aw_have && st_r.w_have && !st_r.s.bvalid) begin
			st_nxt.aw_have = 1'b0;
			st_nxt.w_have = 1'b0;
			st_nxt.s.bvalid = 1'b1;
			st_nxt.s.bresp = RESP_OKAY;
			if (is_result(waddr)) begin
				// threshold word is taken as written, in the current alignment
				st_nxt.result[wch] = merge16(st_r.result[wch], st_r.w_data,
					st_r.w_strb); // see RL15
				if (st_r.ctl2[CTL2_FFC]) begin
					clr_ccf[wch] = 1'b1; // see RL21
				end
			end else begin
				unique case (waddr)
					OFS_CTL0:  st_nxt.ctl0 = merge8(st_r.ctl0, st_r.w_data, st_r.w_strb, 0);
					OFS_CTL1:  st_nxt.ctl1 = merge8(st_r.ctl1, st_r.w_data, st_r.w_strb, 0);
					OFS_CTL2:  st_nxt.ctl2 = merge8(st_r.ctl2, st_r.w_data, st_r.w_strb, 0);
					OFS_CTL3:  st_nxt.ctl3 = merge8(st_r.ctl3, st_r.w_data, st_r.w_strb, 0);
					OFS_CTL4:  st_nxt.ctl4 = merge8(st_r.ctl4, st_r.w_data, st_r.w_strb, 0);
					OFS_CTL5: begin
						st_nxt.ctl5 = merge8(st_r.ctl5, st_r.w_data, st_r.w_strb, 0);
						// any write restarts, even one that leaves the value unchanged
						st_nxt.start = 1'b1; // see RL13
					end
					OFS_STAT0: begin
						if (st_r.w_strb[0]) begin
							clr_scf = st_r.w_data[STAT0_SCF];
						end
					end
					OFS_CCF: begin
						clr_ccf = clr_ccf | (merge16(16'h0000, st_r.w_data,
							st_r.w_strb) & st_r.ccf); // see RL16
					end
					OFS_CMPE:  st_nxt.cmp_en = merge16(st_r.cmp_en, st_r.w_data,
						st_r.w_strb); // see RL9
					OFS_CMPHT: st_nxt.cmp_ht = merge16(st_r.cmp_ht, st_r.w_data,
						st_r.w_strb); // see RL10
					OFS_CMPF: begin
						clr_cmp = merge16(16'h0000, st_r.w_data, st_r.w_strb);
					end
					default: begin
						st_nxt.s.bresp = RESP_SLVERR;
					end
				endcase
			end
		end

		// register read; reading never clears a flag unless fast clear is on
		if (axi_m.arvalid && st_r.s.arready) begin
			if (is_result(raddr)) begin
				rd = {16'h0000, st_r.result[rch]};
				if (st_r.ctl2[CTL2_FFC]) begin
					clr_ccf[rch] = 1'b1; // see RL21
				end
			end else begin
				unique case (raddr)
					OFS_CTL0:  rd = {24'h000000, st_r.ctl0};
					OFS_CTL1:  rd = {24'h000000, st_r.ctl1};
					OFS_CTL2:  rd = {24'h000000, st_r.ctl2};
					OFS_CTL3:  rd = {24'h000000, st_r.ctl3};
					OFS_CTL4:  rd = {24'h000000, st_r.ctl4};
					OFS_CTL5:  rd = {24'h000000, st_r.ctl5};
					OFS_STAT0: begin
						rd[STAT0_SCF] = st_r.sequence_complete_flag; // see RL22
						rd[STAT0_CMP] = |st_r.cmp_flag; // see RL7
						rd[STAT0_BUSY] = st_r.busy;
					end
					OFS_CCF:   rd = {16'h0000, st_r.ccf}; // see RL16
					OFS_CMPE:  rd = {16'h0000, st_r.cmp_en};
					OFS_CMPHT: rd = {16'h0000, st_r.cmp_ht};
					OFS_CMPF:  rd = {16'h0000, st_r.cmp_flag};
					default:   rd_ok = 1'b0;
				endcase
			end
			st_nxt.s.rvalid = 1'b1;
			st_nxt.s.rdata = rd;
			st_nxt.s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end

		// software clears first, so a hardware set in the same cycle wins
		st_nxt.ccf = st_r.ccf & ~clr_ccf;
		st_nxt.cmp_flag = st_r.cmp_flag & ~clr_cmp;
		if (clr_scf) begin
			st_nxt.sequence_complete_flag = 1'b0;
		end

		// sequencer
		if (st_r.start) begin
			st_nxt.busy = 1'b1;
			st_nxt.ch = st_r.ctl5[CTL5_CH_LO +: 4];
			st_nxt.left = (st_r.ctl3[CTL3_LEN_LO +: 4] == 4'h0) ? 5'd16 :
				{1'b0, st_r.ctl3[CTL3_LEN_LO +: 4]};
			st_nxt.sequence_complete_flag = 1'b0;
		end else if (st_r.busy && conv_done) begin
			val = justify(conv_raw, st_r.ctl1[CTL1_RES_LO +: 2],
				st_r.ctl3[CTL3_JUSTIFY]); // see RL14
			thr = st_r.result[st_r.ch]; // see RL8
			match = st_r.cmp_ht[st_r.ch] ? (val > thr) : (val <= thr); // see RL10
			if (st_r.cmp_en[st_r.ch]) begin
				// threshold kept in place; only the event is recorded
				if (match) begin
					st_nxt.cmp_flag[st_r.ch] = 1'b1; // see RL6
					st_nxt.ccf[st_r.ch] = 1'b1;
					if (stop_mode) begin
						st_nxt.wake = 1'b1; // see RL19
					end
				end
			end else begin
				st_nxt.result[st_r.ch] = val; // see RL20
				st_nxt.ccf[st_r.ch] = 1'b1;
			end
			if (st_r.ctl5[CTL5_MULT]) begin
				nch = (st_r.ch == st_r.ctl0[CTL0_WRAP_LO +: 4]) ? 4'h0 :
					4'(st_r.ch + 4'h1); // see RL1
			end else begin
				nch = st_r.ch;
			end
			st_nxt.ch = nch;
			st_nxt.left = st_r.left - 5'd1;
			if (st_r.left == 5'd1) begin
				st_nxt.busy = 1'b0; // see RL17
				st_nxt.sequence_complete_flag = 1'b1; // see RL22
			end
		end

		if (!stop_mode) begin
			st_nxt.wake = 1'b0;
		end
		st_nxt.irq = st_nxt.ctl2[CTL2_CMPIE] && (|st_nxt.cmp_flag); // see RL5

		// ready only while the holding slot is free
		st_nxt.s.awready = !st_nxt.aw_have && !st_nxt.s.awready;
		st_nxt.s.wready = !st_nxt.w_have && !st_nxt.s.wready;
		st_nxt.s.arready = !st_nxt.s.rvalid && !st_nxt.s.arready;
	end

	// a held conversion stays frozen in stop unless the internal clock is kept on
	assign conv_hold = stop_mode && !st_r.ctl2[CTL2_STOPCLK]; // see RL4

	always_comb begin
		cfg.drain = st_r.ctl1[CTL1_DRAIN]; // see RL2
		cfg.sample_code = {st_r.ctl4[CTL4_SAMPLE_TIME_BIT2], st_r.ctl4[CTL4_SMP_LO +: 2]}; // see RL11
		cfg.resolution = st_r.ctl1[CTL1_RES_LO +: 2]; // see RL3
	end

	adc_conv_core u_core (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.start       (st_r.start || (st_r.busy && conv_done && st_r.left != 5'd1)),
		.hold        (conv_hold),
		.cfg         (cfg),
		.analog_data (analog_data),
		.done        (conv_done),
		.raw         (conv_raw),
		.sampling    (conv_sampling),
		.draining    (conv_draining)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// usable straight out of reset, no power-up step
			st_r <= '0; // see RL17
			st_r.ctl0 <= CTL0_RST;
			st_r.ctl1 <= CTL1_RST;
			st_r.ctl2 <= CTL2_RST;
			st_r.ctl3 <= CTL3_RST;
			st_r.ctl4 <= CTL4_RST;
			st_r.ctl5 <= CTL5_RST;
			st_r.cmp_en <= CMPE_RST; // see RL9
			st_r.cmp_ht <= CMPHT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// pin copies of channel, special select and conversion phase, registered once more
	logic [3:0] ch_q;
	logic       sc_q;
	logic       smp_q;
	logic       drn_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch_q <= 4'h0;
			sc_q <= 1'b0;
			smp_q <= 1'b0;
			drn_q <= 1'b0;
		end else begin
			ch_q <= st_r.ch;
			sc_q <= st_r.ctl5[CTL5_SPECIAL]; // see RL12
			smp_q <= conv_sampling;
			drn_q <= conv_draining; // see RL2
		end
	end

	assign axi_s            = st_r.s;
	assign channel_sel      = ch_q;
	assign special_sel      = sc_q;
	assign sample_active    = smp_q;
	assign discharge_active = drn_q;
	assign compare_irq      = st_r.irq;
	assign wakeup_req       = st_r.wake;
endmodule

//--- verif/adc_sequencer_compare_ctrl_asserts.sv
module adc_sequencer_compare_ctrl_asserts (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire adc_pkg::axi_m_type axi_m,
	input wire adc_pkg::axi_s_type axi_s,
	input wire logic               stop_mode,
	input wire logic [11:0]        analog_data,
	input wire logic [3:0]         channel_sel,
	input wire logic               special_sel,
	input wire logic               sample_active,
	input wire logic               discharge_active,
	input wire logic               compare_irq,
	input wire logic               wakeup_req
);
	import adc_pkg::*;
	logic       aw_take;
	logic [2:0] tk_r;
	logic       spec_r;
	logic       started_r;
	assign aw_take = axi_m.awvalid && axi_s.awready;
	// write and data are offered together, so wdata is valid at the address take
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tk_r      <= 3'h0;
			spec_r    <= 1'b0;
			started_r <= 1'b0;
		end else begin
			tk_r <= {tk_r[1:0], aw_take};
			if (aw_take && axi_m.awaddr == OFS_CTL5) begin
				spec_r    <= axi_m.wdata[CTL5_SPECIAL];
				started_r <= 1'b1;
			end
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_drain_apart: assert property (!(discharge_active && sample_active))
		else $error("drain overlaps sampling");
	a_drain_length: assert property ($rose(discharge_active) |->
		discharge_active[*4] ##1 !discharge_active) else $error("drain length wrong");
	a_drain_to_sample: assert property ($fell(discharge_active) |->
		##[0:1] sample_active) else $error("drain not followed by sampling");
	a_wake_clear: assert property (!stop_mode |=> !wakeup_req)
		else $error("wakeup outside stop");
	a_wake_in_stop: assert property ($rose(wakeup_req) |-> $past(stop_mode))
		else $error("wakeup raised without stop");
	a_special_match: assert property ($fell(sample_active) |-> special_sel == spec_r)
		else $error("special select differs from last start");
	a_idle_reset: assert property (!started_r |-> !sample_active && !discharge_active)
		else $error("activity before any start");
	a_ready_reset: assert property ($rose(aresetn) |->
		##[0:2] (axi_s.awready && axi_s.arready)) else $error("bus not ready after reset");
	a_start_seq: assert property (aw_take && axi_m.awaddr == OFS_CTL5 && !stop_mode |->
		##[1:12] (sample_active || discharge_active)) else $error("start write without sequence");
	a_irq_holds: assert property (compare_irq && !aw_take && tk_r == 3'h0 |=> compare_irq)
		else $error("compare irq dropped without a write");
endmodule

bind adc_sequencer_compare_ctrl adc_sequencer_compare_ctrl_asserts
	i_adc_sequencer_compare_ctrl_asserts (
	.aclk(aclk), .aresetn(aresetn), .axi_m(axi_m), .axi_s(axi_s), .stop_mode(stop_mode),
	.analog_data(analog_data), .channel_sel(channel_sel), .special_sel(special_sel),
	.sample_active(sample_active), .discharge_active(discharge_active),
	.compare_irq(compare_irq), .wakeup_req(wakeup_req));

//--- verif/adc_sequencer_compare_ctrl_tb_top.sv
module adc_sequencer_compare_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import adc_pkg::*;
	logic aclk, aresetn, stop_mode, special_sel, sample_active, discharge_active;
	logic compare_irq, wakeup_req, prev_s, drn_seen, m;
	logic [11:0] analog_data, ad, thr;
	logic [3:0]  channel_sel, ch_last, ch;
	logic [15:0] rs;
	logic [31:0] rdv;
	logic [1:0]  rsp;
	axi_m_type   axi_m;
	axi_s_type   axi_s;
	int          fail_count, num_checks, scnt, last_len;
	logic [3:0]  chq[$];
	logic [7:0]  ra[8] = '{OFS_CTL0, OFS_CTL1, OFS_CTL2, OFS_CTL3, OFS_CTL4, OFS_CTL5,
		OFS_CMPE, OFS_CMPHT};
	logic [31:0] rv[8] = '{32'(CTL0_RST), 32'(CTL1_RST), 32'(CTL2_RST), 32'(CTL3_RST),
		32'(CTL4_RST), 32'(CTL5_RST), 32'(CMPE_RST), 32'(CMPHT_RST)};
	logic [7:0]  wa[4] = '{OFS_CTL1, OFS_CTL4, OFS_CMPE, OFS_CMPHT};
	logic [15:0] wm[4] = '{16'h0070, 16'h00E0, 16'hFFFF, 16'hFFFF};
	int          tk[8] = '{4, 6, 8, 10, 12, 16, 20, 24};

	adc_sequencer_compare_ctrl i_adc_sequencer_compare_ctrl (
		.aclk(aclk), .aresetn(aresetn), .axi_m(axi_m), .axi_s(axi_s), .stop_mode(stop_mode),
		.analog_data(analog_data), .channel_sel(channel_sel), .special_sel(special_sel),
		.sample_active(sample_active), .discharge_active(discharge_active),
		.compare_irq(compare_irq), .wakeup_req(wakeup_req));

	always #4 aclk = ~aclk;

	// sample phase length and channel seen, taken at the end of each sample
	always @(posedge aclk) begin
		prev_s <= sample_active;
		if (discharge_active === 1'b1) drn_seen <= 1'b1;
		if (sample_active === 1'b1) begin
			scnt <= scnt + 1;
			ch_last <= channel_sel;
		end else scnt <= 0;
		if (prev_s === 1'b1 && sample_active === 1'b0) begin
			last_len <= scnt;
			chq.push_back(ch_last);
		end
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// truncation to the chosen width, then optional left alignment in 16 bits
	function automatic logic [31:0] exp_res(input logic [11:0] a, input int r, input logic j);
		int b;
		logic [31:0] v;
		b = (r == 0) ? 8 : (r == 1) ? 10 : 12;
		v = 32'(a >> (12 - b));
		return j ? (v << (16 - b)) : v;
	endfunction

	task automatic complete_run();
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic time_out();
		chk("wait bound", 32'h0, 32'h1);
		complete_run();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		axi_m.awaddr <= a;
		axi_m.wdata <= d;
		axi_m.wstrb <= 4'hF;
		axi_m.awvalid <= 1'b1;
		axi_m.wvalid <= 1'b1;
		axi_m.bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (axi_s.awready === 1'b1) axi_m.awvalid <= 1'b0;
			if (axi_s.wready === 1'b1) axi_m.wvalid <= 1'b0;
		end while (axi_s.bvalid !== 1'b1 && n < 100);
		axi_m.bready <= 1'b0;
		if (n >= 100) time_out();
		chk("bresp", 32'(er), 32'(axi_s.bresp));
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		axi_m.araddr <= a;
		axi_m.arvalid <= 1'b1;
		axi_m.rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (axi_s.arready === 1'b1) axi_m.arvalid <= 1'b0;
		end while (axi_s.rvalid !== 1'b1 && n < 100);
		axi_m.rready <= 1'b0;
		rdv = axi_s.rdata;
		rsp = axi_s.rresp;
		if (n >= 100) time_out();
	endtask

	// start by control 5, poll sequence complete, then clear it
	task automatic conv(input logic [7:0] c5);
		int n;
		n = 0;
		wr(OFS_CTL5, 32'(c5), RESP_OKAY);
		do begin
			rd(OFS_STAT0);
			n++;
		end while (rdv[STAT0_SCF] !== 1'b1 && n < 200);
		if (n >= 200) time_out();
		wr(OFS_STAT0, 32'h80, RESP_OKAY);
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		stop_mode = 1'b0;
		analog_data = 12'h000;
		axi_m = '0;
		rs = 16'h001C;
		fail_count = 0;
		num_checks = 0;
		scnt = 0;
		prev_s = 1'b0;
		drn_seen = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			rd(ra[i]);
			chk("reset value", rv[i], rdv);
		end
		rd(8'h30);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(rsp));
		chk("unmapped rdata", 32'h0, rdv);
		wr(8'h30, 32'h1, RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			rs = lfsr(rs);
			wr(wa[i], 32'(rs & wm[i]), RESP_OKAY);
			rd(wa[i]);
			chk("readback", 32'(rs & wm[i]), rdv);
			wr(wa[i], 32'h0, RESP_OKAY);
		end
		for (int r = 0; r < 3; r++) begin
			for (int j = 0; j < 2; j++) begin
				rs = lfsr(rs);
				ad = rs[11:0];
				ch = 4'(r * 2 + j);
				analog_data <= ad;
				wr(OFS_CTL1, 32'(r) << CTL1_RES_LO, RESP_OKAY);
				wr(OFS_CTL3, {24'h0, j[0], 7'h08}, RESP_OKAY);
				conv({4'h0, ch});
				rd(8'(OFS_RES_BASE + {ch, 2'b00}));
				chk("result", exp_res(ad, r, j[0]), rdv);
				rd(OFS_STAT0);
				chk("compare status", 32'h0, 32'(rdv[STAT0_CMP]));
				rd(OFS_CCF);
				chk("complete kept", 32'h1, 32'(rdv[ch]));
				wr(OFS_CCF, 32'h1 << ch, RESP_OKAY);
				rd(OFS_CCF);
				chk("complete cleared", 32'h0, 32'(rdv[ch]));
			end
		end
		// drain on and full resolution from here on
		wr(OFS_CTL1, 32'h50, RESP_OKAY);
		wr(OFS_CTL3, 32'h08, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			drn_seen = 1'b0;
			wr(OFS_CTL4, 32'(i) << CTL4_SMP_LO, RESP_OKAY);
			conv(8'h00);
			chk("sample length", 32'(tk[i] * CONV_CLK_DIV), 32'(last_len));
			chk("drain seen", 32'h1, 32'(drn_seen));
		end
		wr(OFS_CTL0, 32'h7, RESP_OKAY);
		wr(OFS_CTL3, 32'h20, RESP_OKAY);
		chq.delete();
		conv(8'h16);
		for (int k = 0; k < 4; k++) begin
			chk("wrap channel", 32'((6 + k) % 8), 32'(chq[k]));
		end
		wr(OFS_CTL3, 32'h08, RESP_OKAY);
		conv(8'h40);
		chk("special select", 32'h1, 32'(special_sel));
		wr(OFS_CTL2, 32'h40, RESP_OKAY);
		conv(8'h03);
		rd(OFS_RES_BASE + 8'h0C);
		rd(OFS_CCF);
		chk("fast clear", 32'h0, 32'(rdv[3]));
		wr(OFS_CTL2, 32'h01, RESP_OKAY);
		for (int h = 0; h < 4; h++) begin
			ch = 4'(8 + h);
			rs = lfsr(rs);
			ad = rs[11:0];
			rs = lfsr(rs);
			thr = (h >= 2) ? ad : rs[11:0];
			analog_data <= ad;
			wr(8'(OFS_RES_BASE + {ch, 2'b00}), 32'(thr), RESP_OKAY);
			rd(8'(OFS_RES_BASE + {ch, 2'b00}));
			chk("threshold", 32'(thr), rdv);
			wr(OFS_CMPE, 32'h1 << ch, RESP_OKAY);
			wr(OFS_CMPHT, 32'(h % 2) << ch, RESP_OKAY);
			conv({4'h0, ch});
			m = (h % 2) ? (ad > thr) : (ad <= thr);
			rd(OFS_CMPF);
			chk("compare flag", 32'(m), 32'(rdv[ch]));
			chk("compare irq", 32'(m), 32'(compare_irq));
			wr(OFS_CMPF, 32'hFFFF, RESP_OKAY);
		end
		wr(OFS_CTL2, 32'h21, RESP_OKAY);
		wr(OFS_CMPE, 32'h1, RESP_OKAY);
		wr(OFS_CMPHT, 32'h1, RESP_OKAY);
		wr(OFS_RES_BASE, 32'h0, RESP_OKAY);
		analog_data <= 12'hFFF;
		stop_mode <= 1'b1;
		conv(8'h00);
		chk("wakeup", 32'h1, 32'(wakeup_req));
		stop_mode <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("wakeup low", 32'h0, 32'(wakeup_req));
		complete_run();
	end
endmodule
